// ==== svm_cpu_model.sv ====
// Purpose: CPU side model that takes branch offers and ends services
// Assumes: one offer at a time, everything on clk_sys_in
// Notes: transfers do not nest, so they never get a return pulse
`timescale 1ns/1ns
module svm_cpu_model #(
	parameter int ACK_DLY = 2,
	parameter int SVC_CYC = 40
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Offer from the block
	input wire logic req_in,
	input wire logic [6:0] num_in,
	input wire logic [8:0] vec_in,
	input wire logic xfer_in,
	// Answer and record of the last take
	output logic ack_out,
	output logic ret_out,
	output int taken_out,
	output logic [6:0] num_out,
	output logic [8:0] vec_out,
	output logic xfer_out
);
	int wait_q;
	int tmr_q;
	int depth_q;
	int d;
	always @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			ack_out <= 1'b0;
			ret_out <= 1'b0;
			taken_out <= 0;
			wait_q <= 0;
			tmr_q <= 0;
			depth_q <= 0;
		end
		else
		begin
			d = depth_q;
			ret_out <= 1'b0;
			ack_out <= 1'b0;
			wait_q <= req_in ? wait_q + 1 : 0;
			// Slow answer: the offer must stand ACK_DLY cycles first
			if (req_in && !ack_out && wait_q >= ACK_DLY)
				ack_out <= 1'b1;
			if (tmr_q > 0)
				tmr_q <= tmr_q - 1;
			else if (d > 0)
			begin
				ret_out <= 1'b1;
				d = d - 1;
				tmr_q <= SVC_CYC;
			end
			if (req_in && ack_out)
			begin
				taken_out <= taken_out + 1;
				num_out <= num_in;
				vec_out <= vec_in;
				xfer_out <= xfer_in;
				wait_q <= 0;
				if (!xfer_in)
				begin
					d = d + 1;
					tmr_q <= SVC_CYC;
				end
			end
			depth_q <= d;
		end
	end
endmodule

// ==== svm_pkg.sv ====
// Purpose: constants for the shared vector interrupt multiplexer
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: route table gives the source index at each flag position
package svm_pkg;
	localparam int NV = 4;
	localparam int NSRC = 14;
	localparam int NTRAP = 9;
	localparam int NTRAP_A = 3;
	localparam int STK_DEPTH = 16;
	// Register byte offsets
	localparam logic [7:0] OFS_SEL [0:3] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	localparam logic [7:0] OFS_VCTL = 8'h10;
	localparam logic [7:0] OFS_TRAP = 8'h14;
	localparam logic [7:0] OFS_ISTAT = 8'h18;
	localparam logic [7:0] OFS_IMASK = 8'h1C;
	localparam logic [7:0] OFS_CORE = 8'h20;
	// Field positions and reset values
	localparam int SEL_EN_LSB = 8;
	localparam int VCTL_XFER_BIT = 4;
	localparam logic [31:0] VCTL_MASK = 32'h1F1F1F1F;
	localparam logic [15:0] SEL_RST = 16'h0000;
	localparam logic [31:0] VCTL_RST = 32'h00000000;
	localparam logic [4:0] IMASK_RST = 5'h00;
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [3:0] LEVEL_TRAP = 4'hF;
	localparam int ISTAT_TRAP_BIT = 4;
	// Trap numbers; vector location is four times the number
	localparam logic [6:0] TNUM_SHARED0 = 7'h40;
	localparam logic [6:0] TNUM_A [0:2] = '{7'h02, 7'h04, 7'h06};
	localparam logic [6:0] TNUM_B = 7'h0A;
	localparam logic [1:0] RANK_NONE = 2'h0;
	localparam logic [1:0] RANK_B = 2'h1;
	localparam logic [1:0] RANK_A = 2'h2;
	// Source indices on src_event_in
	localparam logic [3:0] S_CAN1 = 4'h0;
	localparam logic [3:0] S_CAN2 = 4'h1;
	localparam logic [3:0] S_I2C_RX = 4'h2;
	localparam logic [3:0] S_I2C_TX = 4'h3;
	localparam logic [3:0] S_I2C_ERR = 4'h4;
	localparam logic [3:0] S_SYNC_RX = 4'h5;
	localparam logic [3:0] S_SYNC_TX = 4'h6;
	localparam logic [3:0] S_SYNC_ERR = 4'h7;
	localparam logic [3:0] S_ASYN_RX = 4'h8;
	localparam logic [3:0] S_ASYN_TX = 4'h9;
	localparam logic [3:0] S_ASYN_TB = 4'hA;
	localparam logic [3:0] S_ASYN_ERR = 4'hB;
	localparam logic [3:0] S_PLL_OWD = 4'hC;
	localparam logic [3:0] S_PWM = 4'hD;
	localparam logic [3:0] S_NONE = 4'hF;
	localparam logic [3:0] ROUTE [0:3][0:7] = '{
		'{S_CAN1, S_I2C_RX, S_I2C_TX, S_SYNC_RX, S_SYNC_TX, S_ASYN_RX, S_ASYN_TX, S_ASYN_TB},
		'{S_CAN2, S_I2C_RX, S_I2C_TX, S_SYNC_RX, S_SYNC_TX, S_ASYN_RX, S_ASYN_TX, S_ASYN_TB},
		'{S_PWM, S_I2C_RX, S_I2C_TX, S_SYNC_RX, S_SYNC_TX, S_ASYN_RX, S_ASYN_TX, S_ASYN_TB},
		'{S_CAN1, S_CAN2, S_I2C_ERR, S_SYNC_ERR, S_ASYN_ERR, S_PLL_OWD, S_PWM, S_NONE}};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== svm_shared_vector_irq_mux.sv ====
// Purpose: shared vector multiplexer, trap flags and branch arbitration
// Assumes: sources, traps and CPU handshake are on clk_sys_in
// Notes: one offer at a time; CPU answers with ack and later return
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
// How it works
// - Four 16-bit select registers, one for each shared vector.
// - Select bits 15:8 are per-source enables, read and write.
// - Select bits 7:0 are per-source pending flags.
// - A flag only requests the vector when its enable is set.
// - Flags set on events even while their enable is clear.
// - Identical select, mask and flag logic for all four vectors.
// - Routing of CAN, I2C, serial and buffer events to vectors 0..3.
// - Error and PLL/watchdog events go to vector 3; PWM to 2 and 3.
// - Shared vectors use trap numbers 40h to 43h, four bytes apart.
// - Vector location equals four times the trap number.
// - Each source has flag and enable; interrupt or transfer per vector.
// - Hardware traps branch ignoring every enable, once their rank allows it.
// - Each trap sets its own bit in the trap flag register.
// - A trap pre-empts unless a trap service of equal or higher rank is running.
// - Interrupts and transfers never interrupt a trap service.
// - Sixteen levels; an interrupt only pre-empts a lower level, a trap pre-empts any interrupt.
// - Trap service forces the CPU level to 15.
module svm_shared_vector_irq_mux (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Event sources
	input wire logic [13:0] src_event_in,
	input wire logic [8:0] trap_event_in,
	// CPU handshake
	input wire logic cpu_ack_in,
	input wire logic cpu_return_in,
	output logic branch_req_out,
	output logic [6:0] branch_trap_num_out,
	output logic [8:0] branch_vector_out,
	output logic branch_xfer_out,
	output logic [3:0] cpu_level_out,
	output logic trap_active_out,
	output logic [3:0] shared_vector_req_out,
	output logic irq_out,
	// AXI4-Lite slave
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [7:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out
);
	logic [15:0] sel_q [0:3], sel_d [0:3];
	logic [31:0] vctl_q, vctl_d;
	logic [8:0] tflag_q, tflag_d, tpend_q, tpend_d;
	logic [4:0] istat_q, istat_d, imask_q, imask_d, sp_q, sp_d;
	logic irq_q, irq_d;
	logic [3:0] served_q, served_d, vreq_q, vreq_d, vnow, vnew, lvl_q, lvl_d;
	logic [3:0] stk_lvl_q [0:15], stk_lvl_d [0:15];
	logic [1:0] stk_rank_q [0:15], stk_rank_d [0:15];
	logic of_v_q, of_v_d, of_trap_q, of_trap_d, of_x_q, of_x_d;
	logic [6:0] of_num_q, of_num_d, t_num;
	logic [3:0] of_lvl_q, of_lvl_d, i_lvl, lv, sel_wr;
	logic [1:0] of_rank_q, of_rank_d, of_idx_q, of_idx_d, rank_q, rank_d, t_rank, i_idx;
	logic awr_q, awr_d, awh_q, awh_d, wr_q, wr_d, wh_q, wh_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d, rd_mux;
	logic [3:0] wstb_q, wstb_d;
	logic bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic wr_fire, ar_take, take, hit, t_ok, i_ok, t_v, i_v, full, rd_ok, wr_ok;

	assign wr_fire = awh_q && wh_q && !bv_q;
	assign ar_take = s_axi_arvalid_in && arr_q;
	assign take = of_v_q && cpu_ack_in;
	assign full = (sp_q == 5'(svm_pkg::STK_DEPTH));

	always_comb
	begin
		// Bus handshakes: address and data are caught in either order
		awh_d = wr_fire ? 1'b0 : (awh_q || (s_axi_awvalid_in && awr_q));
		wh_d = wr_fire ? 1'b0 : (wh_q || (s_axi_wvalid_in && wr_q));
		awr_d = !awh_d;
		wr_d = !wh_d;
		awa_d = (s_axi_awvalid_in && awr_q) ? s_axi_awaddr_in : awa_q;
		wdat_d = (s_axi_wvalid_in && wr_q) ? s_axi_wdata_in : wdat_q;
		wstb_d = (s_axi_wvalid_in && wr_q) ? s_axi_wstrb_in : wstb_q;
		for (int v = 0; v < svm_pkg::NV; v++)
			sel_wr[v] = wr_fire && (awa_q[7:2] == svm_pkg::OFS_SEL[v][7:2]);
		// Registers fill one run of words, select 0 up to core status
		wr_ok = (awa_q[7:2] <= svm_pkg::OFS_CORE[7:2]);
		bv_d = wr_fire ? 1'b1 : (bv_q && !s_axi_bready_in);
		bresp_d = wr_fire ? (wr_ok ? svm_pkg::RESP_OKAY : svm_pkg::RESP_SLVERR) : bresp_q;

		// Same structure for every shared vector; flag set beats clear
		for (int v = 0; v < svm_pkg::NV; v++)
		begin
			sel_d[v] = sel_q[v];
			vnew[v] = 1'b0;
			hit = 1'b0;
			vnow[v] = |(sel_q[v][15:8] & sel_q[v][7:0]);
			for (int b = 0; b < 8; b++)
			begin
				if (svm_pkg::ROUTE[v][b] == svm_pkg::S_NONE)
				begin
					sel_d[v][b] = 1'b0;
					sel_d[v][b + svm_pkg::SEL_EN_LSB] = 1'b0;
				end
				else
				begin
					hit = src_event_in[svm_pkg::ROUTE[v][b]];
					if (sel_wr[v] && wstb_q[1])
						sel_d[v][b + 8] = wdat_q[b + 8];
					if (hit)
						sel_d[v][b] = 1'b1;
					else if (sel_wr[v] && wstb_q[0] && !wdat_q[b])
						sel_d[v][b] = 1'b0;
					if (hit && sel_q[v][b + 8])
						vnew[v] = 1'b1;
				end
			end
			vreq_d[v] = |(sel_d[v][15:8] & sel_d[v][7:0]);
		end

		vctl_d = vctl_q;
		imask_d = imask_q;
		tflag_d = tflag_q;
		if (wr_fire && awa_q[7:2] == svm_pkg::OFS_VCTL[7:2])
			for (int k = 0; k < 4; k++)
				if (wstb_q[k])
					vctl_d[k*8 +: 8] = wdat_q[k*8 +: 8] & svm_pkg::VCTL_MASK[k*8 +: 8];
		if (wr_fire && wstb_q[0] && awa_q[7:2] == svm_pkg::OFS_IMASK[7:2])
			imask_d = wdat_q[4:0];
		for (int t = 0; t < svm_pkg::NTRAP; t++)
		begin
			if (trap_event_in[t])
				tflag_d[t] = 1'b1;
			else if (wr_fire && wstb_q[t / 8] && !wdat_q[t]
				&& awa_q[7:2] == svm_pkg::OFS_TRAP[7:2])
				tflag_d[t] = 1'b0;
		end

		// Read mux; status clears on read, new events still land
		rd_ok = (s_axi_araddr_in[7:2] <= svm_pkg::OFS_CORE[7:2]);
		rd_mux = 32'h00000000;
		if (s_axi_araddr_in[7:2] == svm_pkg::OFS_VCTL[7:2])
			rd_mux = vctl_q;
		else if (s_axi_araddr_in[7:2] == svm_pkg::OFS_TRAP[7:2])
			rd_mux = {23'h000000, tflag_q};
		else if (s_axi_araddr_in[7:2] == svm_pkg::OFS_ISTAT[7:2])
			rd_mux = {27'h0000000, istat_q};
		else if (s_axi_araddr_in[7:2] == svm_pkg::OFS_IMASK[7:2])
			rd_mux = {27'h0000000, imask_q};
		else if (s_axi_araddr_in[7:2] == svm_pkg::OFS_CORE[7:2])
			rd_mux = {17'h00000, vnow, sp_q, rank_q, lvl_q};
		else
			for (int v = 0; v < svm_pkg::NV; v++)
				if (s_axi_araddr_in[7:2] == svm_pkg::OFS_SEL[v][7:2])
					rd_mux = {16'h0000, sel_q[v]};
		arr_d = ar_take ? 1'b0 : ((rv_q && s_axi_rready_in) ? 1'b1 : arr_q);
		rv_d = ar_take ? 1'b1 : (rv_q && !s_axi_rready_in);
		rdat_d = ar_take ? rd_mux : rdat_q;
		rresp_d = ar_take ? (rd_ok ? svm_pkg::RESP_OKAY : svm_pkg::RESP_SLVERR) : rresp_q;
		istat_d = istat_q;
		if (ar_take && s_axi_araddr_in[7:2] == svm_pkg::OFS_ISTAT[7:2])
			istat_d = 5'h00;
		istat_d = istat_d | {|trap_event_in, vnew};
		irq_d = |(istat_d & imask_d);

		// Trap candidate: class A in index order, then the shared class B
		t_v = 1'b0;
		t_num = svm_pkg::TNUM_B;
		t_rank = svm_pkg::RANK_NONE;
		if (|tpend_q[8:3])
		begin
			t_v = 1'b1;
			t_rank = svm_pkg::RANK_B;
		end
		for (int a = svm_pkg::NTRAP_A - 1; a >= 0; a--)
			if (tpend_q[a])
			begin
				t_v = 1'b1;
				t_num = svm_pkg::TNUM_A[a];
				t_rank = svm_pkg::RANK_A;
			end
		t_ok = t_v && (t_rank > rank_q) && !full;

		// Interrupt candidate: highest level above the CPU, lowest index on ties
		i_v = 1'b0;
		i_idx = 2'h0;
		i_lvl = 4'h0;
		for (int v = svm_pkg::NV - 1; v >= 0; v--)
		begin
			lv = vctl_q[v*8 +: 4];
			if (vnow[v] && !served_q[v] && lv > lvl_q && (!i_v || lv >= i_lvl))
			begin
				i_v = 1'b1;
				i_idx = 2'(v);
				i_lvl = lv;
			end
		end
		i_ok = i_v && (rank_q == svm_pkg::RANK_NONE)
			&& (vctl_q[i_idx*8 + svm_pkg::VCTL_XFER_BIT] || !full);

		// Offer is withheld in the cycle after a take: it was built on stale state
		of_v_d = (t_ok || i_ok) && !take;
		of_trap_d = t_ok;
		of_num_d = t_ok ? t_num : (svm_pkg::TNUM_SHARED0 + {5'h00, i_idx});
		of_lvl_d = t_ok ? svm_pkg::LEVEL_TRAP : i_lvl;
		of_rank_d = t_rank;
		of_idx_d = i_idx;
		of_x_d = !t_ok && vctl_q[i_idx*8 + svm_pkg::VCTL_XFER_BIT];

		// Return pops first, so a take in the same cycle nests on the result
		lvl_d = lvl_q;
		rank_d = rank_q;
		sp_d = sp_q;
		stk_lvl_d = stk_lvl_q;
		stk_rank_d = stk_rank_q;
		tpend_d = tpend_q;
		served_d = served_q;
		if (cpu_return_in && sp_q != 5'h00)
		begin
			sp_d = sp_q - 5'h01;
			lvl_d = stk_lvl_q[sp_d[3:0]];
			rank_d = stk_rank_q[sp_d[3:0]];
		end
		if (take && !(of_x_q && !of_trap_q) && sp_d != 5'(svm_pkg::STK_DEPTH))
		begin
			stk_lvl_d[sp_d[3:0]] = lvl_d;
			stk_rank_d[sp_d[3:0]] = rank_d;
			sp_d = sp_d + 5'h01;
			lvl_d = of_lvl_q;
			if (of_trap_q)
				rank_d = of_rank_q;
		end
		if (take && of_trap_q)
		begin
			if (of_rank_q == svm_pkg::RANK_B)
				tpend_d[8:3] = 6'h00;
			else
				for (int a = 0; a < svm_pkg::NTRAP_A; a++)
					if (svm_pkg::TNUM_A[a] == of_num_q)
						tpend_d[a] = 1'b0;
		end
		tpend_d = tpend_d | trap_event_in;
		for (int v = 0; v < svm_pkg::NV; v++)
		begin
			if (take && !of_trap_q && of_idx_q == 2'(v))
				served_d[v] = 1'b1;
			if (vnew[v] || !vnow[v])
				served_d[v] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			for (int v = 0; v < svm_pkg::NV; v++)
				sel_q[v] <= svm_pkg::SEL_RST;
			for (int s = 0; s < svm_pkg::STK_DEPTH; s++)
			begin
				stk_lvl_q[s] <= svm_pkg::LEVEL_RST;
				stk_rank_q[s] <= svm_pkg::RANK_NONE;
			end
			vctl_q <= svm_pkg::VCTL_RST;
			tflag_q <= 9'h000;
			tpend_q <= 9'h000;
			istat_q <= 5'h00;
			imask_q <= svm_pkg::IMASK_RST;
			irq_q <= 1'b0;
			served_q <= 4'h0;
			vreq_q <= 4'h0;
			lvl_q <= svm_pkg::LEVEL_RST;
			rank_q <= svm_pkg::RANK_NONE;
			sp_q <= 5'h00;
			of_v_q <= 1'b0;
			of_trap_q <= 1'b0;
			of_x_q <= 1'b0;
			of_num_q <= 7'h00;
			of_lvl_q <= 4'h0;
			of_rank_q <= 2'h0;
			of_idx_q <= 2'h0;
			awr_q <= 1'b1;
			awh_q <= 1'b0;
			wr_q <= 1'b1;
			wh_q <= 1'b0;
			awa_q <= 8'h00;
			wdat_q <= 32'h00000000;
			wstb_q <= 4'h0;
			bv_q <= 1'b0;
			bresp_q <= 2'h0;
			arr_q <= 1'b1;
			rv_q <= 1'b0;
			rdat_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end
		else
		begin
			sel_q <= sel_d;
			stk_lvl_q <= stk_lvl_d;
			stk_rank_q <= stk_rank_d;
			vctl_q <= vctl_d;
			tflag_q <= tflag_d;
			tpend_q <= tpend_d;
			istat_q <= istat_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
			served_q <= served_d;
			vreq_q <= vreq_d;
			lvl_q <= lvl_d;
			rank_q <= rank_d;
			sp_q <= sp_d;
			of_v_q <= of_v_d;
			of_trap_q <= of_trap_d;
			of_x_q <= of_x_d;
			of_num_q <= of_num_d;
			of_lvl_q <= of_lvl_d;
			of_rank_q <= of_rank_d;
			of_idx_q <= of_idx_d;
			awr_q <= awr_d;
			awh_q <= awh_d;
			wr_q <= wr_d;
			wh_q <= wh_d;
			awa_q <= awa_d;
			wdat_q <= wdat_d;
			wstb_q <= wstb_d;
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			rdat_q <= rdat_d;
			rresp_q <= rresp_d;
		end
	end

	assign branch_req_out = of_v_q;
	assign branch_trap_num_out = of_num_q;
	assign branch_vector_out = {of_num_q, 2'b00};
	assign branch_xfer_out = of_x_q;
	assign cpu_level_out = lvl_q;
	assign trap_active_out = (rank_q != svm_pkg::RANK_NONE);
	assign shared_vector_req_out = vreq_q;
	assign irq_out = irq_q;
	assign s_axi_awready_out = awr_q;
	assign s_axi_wready_out = wr_q;
	assign s_axi_bvalid_out = bv_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arr_q;
	assign s_axi_rvalid_out = rv_q;
	assign s_axi_rdata_out = rdat_q;
	assign s_axi_rresp_out = rresp_q;

	AST_CAN1_TWO_VECTORS: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		src_event_in[0] && !src_event_in[1] && !sel_q[1][0]
		|=> sel_q[0][0] && sel_q[3][0] && !sel_q[1][0])
		else $error("first CAN event did not flag vectors 0 and 3 only");
	AST_PWM_FLAG_MASKED: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		src_event_in[13] |=> sel_q[2][0] && sel_q[3][6])
		else $error("PWM event lost on vectors 2 or 3");
	AST_REQ_IS_FLAG_AND_EN: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		shared_vector_req_out[3] == |(sel_q[3][15:8] & sel_q[3][7:0]))
		else $error("vector 3 request differs from flag and enable");
	AST_FLAG_STICKY: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		sel_q[1][0] && !sel_wr[1] |=> sel_q[1][0])
		else $error("flag dropped without a software write");
	AST_TRAP_FLAG_SET: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		trap_event_in[5] |=> tflag_q[5] && tpend_q[5])
		else $error("trap event did not set its flag");
	AST_NMI_BRANCH: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		trap_event_in == 9'h001 && tpend_q == 9'h000 && rank_q == 2'h0 && sp_q < 5'h0E
		|-> ##[2:4] (branch_req_out && of_trap_q && branch_trap_num_out == 7'h02))
		else $error("non-maskable trap not offered in time");
	AST_TRAP_LEVEL_15: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		take && of_trap_q && !cpu_return_in |=> cpu_level_out == 4'hF && trap_active_out)
		else $error("trap service did not force level 15");
	AST_NO_IRQ_IN_TRAP: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		trap_active_out |-> !(branch_req_out && !of_trap_q))
		else $error("interrupt offered during trap service");
	AST_HIGHER_ONLY: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		branch_req_out && !of_trap_q |-> of_lvl_q > cpu_level_out)
		else $error("interrupt offered at or below CPU level");
	AST_SHARED_NUMBER: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		branch_req_out && !of_trap_q |-> branch_vector_out == 9'h100 + {5'h00, of_idx_q, 2'b00})
		else $error("shared vector location wrong");
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the shared vector multiplexer
// Assumes: AXI4-Lite master tasks, CPU side from svm_cpu_model
// Notes: expected flags come from the routing table written out below
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic [13:0] src = '0;
	logic [8:0] trp = '0;
	logic ack, ret, breq, bxf, lxf, tact, irq;
	logic [6:0] bnum, lnum, en;
	logic [8:0] bvec, lvec;
	logic [3:0] lvl, vreq;
	int taken, prev, pos;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wrr, bv, arr, rv;
	logic [7:0] awa = '0, ara = '0, ex;
	logic [31:0] wd = '0, rdat, got;
	logic [3:0] ws = '0;
	logic [1:0] bresp, rresp, resp;
	int fails = 0;
	int num_checks = 0;
	// Source index at each flag position of vectors 0..3
	logic [3:0] tbl [0:3][0:7] = '{
		'{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
		'{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
		'{4'hD, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA},
		'{4'h0, 4'h1, 4'h4, 4'h7, 4'hB, 4'hC, 4'hD, 4'hF}};
	always #10 clk = ~clk;
	svm_shared_vector_irq_mux u_dut (.clk_sys_in(clk), .sys_rst_in(rst),
		.src_event_in(src), .trap_event_in(trp), .cpu_ack_in(ack), .cpu_return_in(ret),
		.branch_req_out(breq), .branch_trap_num_out(bnum), .branch_vector_out(bvec),
		.branch_xfer_out(bxf), .cpu_level_out(lvl), .trap_active_out(tact),
		.shared_vector_req_out(vreq), .irq_out(irq),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
		.s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp));
	svm_cpu_model u_cpu (.clk_sys_in(clk), .sys_rst_in(rst), .req_in(breq),
		.num_in(bnum), .vec_in(bvec), .xfer_in(bxf), .ack_out(ack), .ret_out(ret),
		.taken_out(taken), .num_out(lnum), .vec_out(lvec), .xfer_out(lxf));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		ws <= 4'hF;
		br <= 1'b1;
		while (!(ta && tw))
		begin
			@(negedge clk);
			ta = ta | (awv & awr);
			tw = tw | (wv & wrr);
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
		end
		do
			@(negedge clk);
		while (bv !== 1'b1);
		resp = bresp;
		@(posedge clk);
		br <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do
			@(negedge clk);
		while (arr !== 1'b1);
		@(posedge clk);
		arv <= 1'b0;
		do
			@(negedge clk);
		while (rv !== 1'b1);
		got = rdat;
		resp = rresp;
		@(posedge clk);
		rr <= 1'b0;
	endtask
	task automatic pulse(input logic [13:0] s, input logic [8:0] t);
		@(posedge clk);
		src <= s;
		trp <= t;
		@(posedge clk);
		src <= '0;
		trp <= '0;
	endtask
	// Waits for the model to record one more take than p
	task automatic take(input int p);
		int n;
		n = 0;
		while (taken == p && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		chk(32'(taken), 32'(p + 1));
	endtask
	task automatic idle;
		int n;
		n = 0;
		while ((lvl !== 4'h0 || tact !== 1'b0) && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		chk({tact, lvl}, 5'h00);
	endtask
	// Enables 14:8 on, enable 15 off, flags cleared, on all four vectors
	task automatic clr;
		for (int v = 0; v < 4; v++)
			axw(svm_pkg::OFS_SEL[v], 32'h00007F00);
	endtask
	initial
	begin
		#300000;
		fails++;
		$display("watchdog expired");
		wrap_up();
	end
	initial
	begin
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 36; a += 4)
		begin
			axr(8'(a));
			chk(got, 32'h0);
		end
		axr(8'h24);
		chk(got, 32'h0);
		chk(resp, svm_pkg::RESP_SLVERR);
		axw(8'h24, 32'hFFFFFFFF);
		chk(resp, svm_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int s = 0; s < 14; s++)
		begin
			pulse(14'h0001 << s, 9'h000);
			@(negedge clk);
			chk(vreq, 4'h0);
			for (int v = 0; v < 4; v++)
			begin
				for (int p = 0; p < 8; p++)
					ex[p] = (tbl[v][p] == 4'(s));
				axr(svm_pkg::OFS_SEL[v]);
				chk(got, {24'h0, ex});
				axw(svm_pkg::OFS_SEL[v], 32'h0);
			end
		end
		$display("test routing done");
		axw(svm_pkg::OFS_VCTL, 32'h05050505);
		for (int v = 0; v < 4; v++)
		begin
			pos = (v == 3) ? 2 : 0;
			axw(svm_pkg::OFS_SEL[v], 32'h00007F00);
			prev = taken;
			pulse(14'h0001 << tbl[v][pos], 9'h000);
			@(negedge clk);
			chk(vreq, 32'h1 << v);
			take(prev);
			chk(lnum, 7'h40 + v);
			chk(lvec, 9'h100 + 4 * v);
			@(negedge clk);
			chk(lvl, 4'h5);
			axw(svm_pkg::OFS_SEL[v], 32'h00007FFF);
			axr(svm_pkg::OFS_SEL[v]);
			chk(got, 32'h7F00 | (32'h1 << pos));
			axw(svm_pkg::OFS_SEL[v], 32'h00007F00);
			@(negedge clk);
			chk(vreq, 4'h0);
			idle();
		end
		$display("test offers done");
		axw(svm_pkg::OFS_VCTL, 32'h00090305);
		prev = taken;
		pulse(14'h0001, 9'h000);
		take(prev);
		pulse(14'h0002, 9'h000);
		repeat (6) @(negedge clk);
		chk(taken, prev + 1);
		pulse(14'h2000, 9'h000);
		take(prev + 1);
		chk(lnum, 7'h42);
		@(negedge clk);
		chk(lvl, 4'h9);
		take(prev + 2);
		chk(lnum, 7'h41);
		idle();
		clr();
		$display("test priority done");
		axw(svm_pkg::OFS_VCTL, 32'h00000015);
		prev = taken;
		pulse(14'h0001, 9'h000);
		take(prev);
		chk(lxf, 1'b1);
		@(negedge clk);
		chk({tact, lvl}, 5'h00);
		clr();
		$display("test transfer done");
		for (int i = 0; i < 9; i++)
		begin
			prev = taken;
			pulse(14'h0, 9'h001 << i);
			take(prev);
			en = (i < 3) ? 7'(2 + 2 * i) : 7'h0A;
			chk(lnum, en);
			chk(lvec, {en, 2'h0});
			@(negedge clk);
			chk({tact, lvl}, 5'h1F);
			axr(svm_pkg::OFS_TRAP);
			chk(got, 32'h1 << i);
			axw(svm_pkg::OFS_TRAP, 32'h0);
			idle();
		end
		prev = taken;
		pulse(14'h0, 9'h008);
		take(prev);
		pulse(14'h0001, 9'h000);
		repeat (6) @(negedge clk);
		chk(taken, prev + 1);
		pulse(14'h0, 9'h001);
		take(prev + 1);
		chk(lnum, 7'h02);
		take(prev + 2);
		chk(lnum, 7'h40);
		axw(svm_pkg::OFS_TRAP, 32'h0);
		clr();
		idle();
		$display("test traps done");
		axw(svm_pkg::OFS_IMASK, 32'h1F);
		axr(svm_pkg::OFS_ISTAT);
		pulse(14'h0002, 9'h000);
		repeat (3) @(negedge clk);
		chk(irq, 1'b1);
		axr(svm_pkg::OFS_ISTAT);
		chk(got, 32'h0A);
		axr(svm_pkg::OFS_ISTAT);
		chk(got, 32'h0);
		chk(irq, 1'b0);
		clr();
		axw(svm_pkg::OFS_IMASK, 32'h0);
		pulse(14'h0002, 9'h000);
		repeat (3) @(negedge clk);
		chk(irq, 1'b0);
		axr(svm_pkg::OFS_ISTAT);
		chk(got, 32'h0A);
		$display("test irq done");
		wrap_up();
	end
endmodule
